// ---- rtl/sleep_ctrl_pkg.sv ----
// constants and types for the sleep-mode controller
package sleep_ctrl_pkg;
  localparam logic [2:0] KIND_IDLE     = 3'h0;
  localparam logic [2:0] KIND_ADCNR    = 3'h1;
  localparam logic [2:0] KIND_PDOWN    = 3'h2;
  localparam logic [2:0] KIND_PSAVE    = 3'h3;
  localparam logic [2:0] KIND_RSVD_A   = 3'h4;
  localparam logic [2:0] KIND_RSVD_B   = 3'h5;
  localparam logic [2:0] KIND_STBY     = 3'h6;
  localparam logic [2:0] KIND_XSTBY    = 3'h7;
  localparam int         CLK_MHZ       = 10;
  localparam int         IRQ_HOLD_CYC  = 4;
  localparam int         STBY_WAKE_CYC = 6;
  localparam int         BOD_WAKE_US   = 60;
  localparam int         BOD_WAKE_CYC  = BOD_WAKE_US * CLK_MHZ;
  localparam int         BROWNOUT_SLEEP_OFF_BIT_WIN_CYC  = 4;
  localparam logic       BROWNOUT_SLEEP_OFF_BIT_RESET    = 1'b0;
  localparam int         CNT_W         = 16;
  typedef enum logic [2:0] {ST_RUN, ST_SLEEP, ST_STARTUP, ST_HOLD} sleep_state_t;
endpackage : sleep_ctrl_pkg

// ---- rtl/brownout_sleep_off_bit_if.sv ----
// carrier between controller and timed brown-out sleep-off latch
`timescale 1ns/1ps
interface brownout_sleep_off_bit_if;
  logic enableWrite;
  logic valueWrite;
  logic wrData;
  logic offBit;
  modport ctrl  (output enableWrite, output valueWrite, output wrData, input offBit);
  modport latch (input enableWrite, input valueWrite, input wrData, output offBit);
endinterface : brownout_sleep_off_bit_if

// ---- rtl/brownout_sleep_off_bit_latch.sv ----
// brown-out sleep-off bit with timed enable write sequence
`timescale 1ns/1ps
module brownout_sleep_off_bit_latch
  import sleep_ctrl_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic clkEn,
  brownout_sleep_off_bit_if.latch     bus
);
  logic [2:0] winCnt_reg;
  logic [2:0] winCnt_next;
  logic       off_reg;
  logic       off_next;

  // enable opens a short window; value write only lands inside it
  always_comb begin
    winCnt_next = winCnt_reg;
    off_next    = off_reg;
    if (bus.valueWrite && winCnt_reg != 3'h0) begin
      off_next    = bus.wrData;
      winCnt_next = 3'h0;
    end else if (bus.enableWrite) begin
      winCnt_next = 3'(BROWNOUT_SLEEP_OFF_BIT_WIN_CYC);
    end else if (winCnt_reg != 3'h0) begin
      winCnt_next = winCnt_reg - 3'h1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      winCnt_reg <= 3'h0;
      off_reg    <= BROWNOUT_SLEEP_OFF_BIT_RESET;
    end else if (clkEn) begin
      winCnt_reg <= winCnt_next;
      off_reg    <= off_next;
    end
  end

  assign bus.offBit = off_reg;

  chk_brownout_sleep_off_bit_needs_window: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && bus.valueWrite && winCnt_reg == 3'h0) |=> $stable(off_reg))
    else $error("brown-out bit changed without enable window");
endmodule : brownout_sleep_off_bit_latch

// ---- rtl/sleep_mode_controller.sv ----
// sleep-mode controller: clock gating, wake filter and start-up timing
`timescale 1ns/1ps
module sleep_mode_controller
  import sleep_ctrl_pkg::*;
#(
  parameter int unsigned STARTUP_CYC = 16
)(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       clkEn,
  input  wire logic       sleep_arm_bit,
  input  wire logic [2:0] sleep_kind_select,
  input  wire logic       sleepInstr,
  input  wire logic       adcEnabled,
  input  wire logic       asyncTimerOn,
  input  wire logic       bodsEnableWrite,
  input  wire logic       bodsValueWrite,
  input  wire logic       bodsWrData,
  input  wire logic       sysResetReq,
  input  wire logic       external_irq_a,
  input  wire logic       external_irq_b,
  input  wire logic       irqALevelMode,
  input  wire logic       irqBLevelMode,
  input  wire logic       pin_change_irq,
  input  wire logic       twoWireMatch,
  input  wire logic       watchdogIrq,
  input  wire logic       asyncTimerIrq,
  input  wire logic       timerIrq,
  input  wire logic       storeEeReadyIrq,
  input  wire logic       adcDoneIrq,
  input  wire logic       otherIoIrq,
  output logic            cpuClkEn,
  output logic            flashClkEn,
  output logic            ioClkEn,
  output logic            adcClkEn,
  output logic            asyncClkEn,
  output logic            oscEn,
  output logic            brownoutEn,
  output logic            adcStartPulse,
  output logic            coreHold,
  output logic            irqDeliver,
  output logic            resetVector,
  output logic            brownout_sleep_off_bit,
  output logic            asleep
);
  localparam logic [CNT_W-1:0] HOLD_CNT = CNT_W'(IRQ_HOLD_CYC);
  localparam logic [CNT_W-1:0] STBY_CNT = CNT_W'(STBY_WAKE_CYC);
  localparam logic [CNT_W-1:0] BOD_CNT  = CNT_W'(BOD_WAKE_CYC);

  brownout_sleep_off_bit_if bodsBus ();
  assign bodsBus.enableWrite = bodsEnableWrite;
  assign bodsBus.valueWrite  = bodsValueWrite;
  assign bodsBus.wrData      = bodsWrData;

  brownout_sleep_off_bit_latch uBods (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .clkEn   (clkEn),
    .bus     (bodsBus)
  );
  assign brownout_sleep_off_bit = bodsBus.offBit;

  // pin-side wake inputs pass three sync flops and a filter flop; change counted when 2nd and 3rd agree
  localparam int NPIN = 4;
  logic [NPIN-1:0] pinRaw;
  logic [NPIN-1:0] syncA_reg;
  logic [NPIN-1:0] syncB_reg;
  logic [NPIN-1:0] syncC_reg;
  logic [NPIN-1:0] pinStable_reg;
  logic [NPIN-1:0] pinStable_next;
  assign pinRaw = {twoWireMatch, pin_change_irq, external_irq_b, external_irq_a};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_comb begin
        pinStable_next[gi] = pinStable_reg[gi];
        if (syncB_reg[gi] == syncC_reg[gi]) begin
          pinStable_next[gi] = syncC_reg[gi];
        end
      end
      always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
          syncA_reg[gi]     <= 1'b0;
          syncB_reg[gi]     <= 1'b0;
          syncC_reg[gi]     <= 1'b0;
          pinStable_reg[gi] <= 1'b0;
        end else if (clkEn) begin
          syncA_reg[gi]     <= pinRaw[gi];
          syncB_reg[gi]     <= syncA_reg[gi];
          syncC_reg[gi]     <= syncB_reg[gi];
          pinStable_reg[gi] <= pinStable_next[gi];
        end
      end
    end
  endgenerate

  logic irqA, irqB, pcIrq, twMatch;
  assign irqA    = pinStable_reg[0];
  assign irqB    = pinStable_reg[1];
  assign pcIrq   = pinStable_reg[2];
  assign twMatch = pinStable_reg[3];

  sleep_state_t     state_reg, state_next;
  logic [2:0]       kind_reg, kind_next;
  logic             bodOff_reg, bodOff_next;
  logic             wakeIrq_reg, wakeIrq_next;
  logic             levelWake_reg, levelWake_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  logic             adcStart_reg, adcStart_next;
  logic             irqOut_reg, irqOut_next;
  logic             rstVec_reg, rstVec_next;

  // wake qualification per mode
  logic extLevel, extAny, levelOk, deepKind, standbyKind, wakeEv, irqWake;
  always_comb begin
    extAny   = irqA | irqB;
    extLevel = (irqA & irqALevelMode) | (irqB & irqBLevelMode);
    levelOk  = extLevel | pcIrq | twMatch | watchdogIrq;
    deepKind    = (kind_reg != KIND_IDLE) && (kind_reg != KIND_ADCNR);
    standbyKind = (kind_reg == KIND_STBY) || (kind_reg == KIND_XSTBY);
    irqWake = 1'b0;
    case (kind_reg)
      KIND_IDLE:  irqWake = extAny | pcIrq | twMatch | watchdogIrq | asyncTimerIrq
                          | timerIrq | storeEeReadyIrq | adcDoneIrq | otherIoIrq;
      KIND_ADCNR: irqWake = levelOk | adcDoneIrq | storeEeReadyIrq
                          | (asyncTimerIrq & asyncTimerOn);
      KIND_PDOWN, KIND_STBY: irqWake = levelOk;
      KIND_PSAVE, KIND_XSTBY: irqWake = levelOk
                          | (asyncTimerIrq & asyncTimerOn);
      default:    irqWake = 1'b0;
    endcase
    wakeEv = irqWake;
  end

  // main sequence: run, sleep, start-up delay, interrupt hold
  always_comb begin
    state_next     = state_reg;
    kind_next      = kind_reg;
    bodOff_next    = bodOff_reg;
    wakeIrq_next   = wakeIrq_reg;
    levelWake_next = levelWake_reg;
    cnt_next       = cnt_reg;
    adcStart_next  = 1'b0;
    irqOut_next    = 1'b0;
    rstVec_next    = 1'b0;
    case (state_reg)
      ST_RUN: begin
        // reserved codes and a clear arm bit leave the instruction a no-op
        if (sleepInstr && sleep_arm_bit && sleep_kind_select != KIND_RSVD_A
            && sleep_kind_select != KIND_RSVD_B) begin
          state_next    = ST_SLEEP;
          kind_next     = sleep_kind_select;
          adcStart_next = (sleep_kind_select == KIND_ADCNR) && adcEnabled;
          bodOff_next   = bodsBus.offBit && sleep_kind_select != KIND_IDLE
                          && sleep_kind_select != KIND_ADCNR;
        end
      end
      ST_SLEEP: begin
        if (wakeEv) begin
          state_next     = ST_STARTUP;
          wakeIrq_next   = 1'b1;
          levelWake_next = deepKind && !(pcIrq | twMatch | watchdogIrq
                           | asyncTimerIrq);
          if (bodOff_reg) begin
            cnt_next = BOD_CNT;
          end else if (standbyKind) begin
            cnt_next = STBY_CNT;
          end else if (deepKind) begin
            cnt_next = CNT_W'(STARTUP_CYC);
          end else begin
            cnt_next = CNT_W'(1);
          end
        end
      end
      ST_STARTUP: begin
        if (cnt_reg > CNT_W'(1)) begin
          cnt_next = cnt_reg - CNT_W'(1);
        end else begin
          bodOff_next = 1'b0;
          state_next  = ST_HOLD;
          cnt_next    = HOLD_CNT;
          // level gone before start-up ended: wake without interrupt
          if (levelWake_reg && !extLevel) begin
            wakeIrq_next = 1'b0;
          end
        end
      end
      ST_HOLD: begin
        if (cnt_reg > CNT_W'(1)) begin
          cnt_next = cnt_reg - CNT_W'(1);
        end else begin
          state_next   = ST_RUN;
          irqOut_next  = wakeIrq_reg;
          wakeIrq_next = 1'b0;
        end
      end
      default: state_next = ST_RUN;
    endcase
    // reset in any state but run overrides state, brown-out and pending wake flag and restarts at the vector
    if (sysResetReq && state_reg != ST_RUN) begin
      state_next   = ST_RUN;
      bodOff_next  = 1'b0;
      wakeIrq_next = 1'b0;
      rstVec_next  = 1'b1;
    end
  end

  // sequencing state; register file and sram are never touched here
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state_reg     <= ST_RUN;
      kind_reg      <= KIND_IDLE;
      bodOff_reg    <= 1'b0;
      wakeIrq_reg   <= 1'b0;
      levelWake_reg <= 1'b0;
      cnt_reg       <= '0;
      adcStart_reg  <= 1'b0;
      irqOut_reg    <= 1'b0;
      rstVec_reg    <= 1'b0;
    end else if (clkEn) begin
      state_reg     <= state_next;
      kind_reg      <= kind_next;
      bodOff_reg    <= bodOff_next;
      wakeIrq_reg   <= wakeIrq_next;
      levelWake_reg <= levelWake_next;
      cnt_reg       <= cnt_next;
      adcStart_reg  <= adcStart_next;
      irqOut_reg    <= irqOut_next;
      rstVec_reg    <= rstVec_next;
    end
  end

  // clock domain gating; start-up keeps clocks up so the oscillator settles
  logic inSleep;
  assign inSleep = (state_reg == ST_SLEEP);
  always_comb begin
    cpuClkEn   = !inSleep;
    flashClkEn = !inSleep;
    ioClkEn    = !inSleep || kind_reg == KIND_IDLE;
    adcClkEn   = !inSleep || kind_reg == KIND_IDLE || kind_reg == KIND_ADCNR;
    asyncClkEn = !inSleep || kind_reg == KIND_IDLE || kind_reg == KIND_ADCNR
                 || kind_reg == KIND_PSAVE || kind_reg == KIND_XSTBY;
    oscEn      = !inSleep || kind_reg == KIND_IDLE || kind_reg == KIND_ADCNR
                 || kind_reg == KIND_STBY || kind_reg == KIND_XSTBY;
  end
  assign brownoutEn    = !(inSleep && bodOff_reg);
  assign adcStartPulse = adcStart_reg;
  assign coreHold      = (state_reg != ST_RUN);
  assign irqDeliver    = irqOut_reg;
  assign resetVector   = rstVec_reg;
  assign asleep        = inSleep;

  chk_noarm_noop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && state_reg == ST_RUN && sleepInstr && !sleep_arm_bit && !sysResetReq)
      |=> state_reg == ST_RUN)
    else $error("sleep entered with arm bit clear");
  chk_adc_autostart: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && state_reg == ST_RUN && sleepInstr && sleep_arm_bit
     && sleep_kind_select == KIND_ADCNR && adcEnabled) |=> adcStartPulse)
    else $error("no adc start on noise reduction entry");
  chk_idle_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && kind_reg == KIND_IDLE) |-> (!cpuClkEn && ioClkEn && adcClkEn))
    else $error("idle clock gating wrong");
  chk_pdown_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && kind_reg == KIND_PDOWN) |-> !(oscEn | ioClkEn | adcClkEn | asyncClkEn))
    else $error("power-down left a clock running");
  chk_edge_nowake: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && inSleep && kind_reg == KIND_PDOWN && !sysResetReq && !pcIrq && !twMatch
     && !watchdogIrq && !(irqA & irqALevelMode) && !(irqB & irqBLevelMode))
      |=> inSleep)
    else $error("woke from power-down on edge interrupt");
  chk_stby_six: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && inSleep && kind_reg == KIND_STBY && wakeEv && !bodOff_reg && !sysResetReq)
      |=> cnt_reg == STBY_CNT)
    else $error("standby wake count is not six");
  chk_hold_four: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && $rose(state_reg == ST_HOLD)) |-> cnt_reg == HOLD_CNT)
    else $error("interrupt hold is not four cycles");
  chk_bod_restore: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!inSleep) |-> brownoutEn)
    else $error("brown-out left off while awake");
  chk_reset_vector: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && sysResetReq && state_reg != ST_RUN) |=> (resetVector && state_reg == ST_RUN))
    else $error("reset in sleep did not restart");

  // more per-mode gating checks, idle included, plus reserved-code and brown-out delay checks; clocks only matter while asleep
  chk_idle_flash: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && kind_reg == KIND_IDLE) |-> (!flashClkEn && asyncClkEn && oscEn))
    else $error("idle flash or async gating wrong");
  chk_adcnr_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && kind_reg == KIND_ADCNR) |-> (!ioClkEn && !cpuClkEn && !flashClkEn
     && adcClkEn && asyncClkEn && oscEn))
    else $error("noise reduction clock gating wrong");
  chk_psave_clocks: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && kind_reg == KIND_PSAVE) |-> (asyncClkEn && !oscEn && !adcClkEn))
    else $error("power-save clock gating wrong");
  chk_stby_osc: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (inSleep && (kind_reg == KIND_STBY || kind_reg == KIND_XSTBY))
      |-> (oscEn && !ioClkEn && !cpuClkEn))
    else $error("standby oscillator gating wrong");
  chk_reserved_noop: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && state_reg == ST_RUN && sleepInstr && (sleep_kind_select == KIND_RSVD_A
     || sleep_kind_select == KIND_RSVD_B)) |=> state_reg == ST_RUN)
    else $error("reserved sleep code entered sleep");
  chk_bod_sixty: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (clkEn && inSleep && wakeEv && bodOff_reg && !sysResetReq) |=> cnt_reg == BOD_CNT)
    else $error("brown-out wake delay not loaded");
  // a low enable must freeze the sequence, or gated clocks could glitch
  chk_freeze_state: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (!clkEn) |=> $stable(state_reg))
    else $error("state moved while clock enable low");
endmodule : sleep_mode_controller

// ---- dv/core_model.sv ----
// core-side model: sleep instructions and timed brown-out bit writes
`timescale 1ns/1ps
module core_model (
  input  wire logic       sys_clk,
  output logic            sleepInstr,
  output logic            armBit,
  output logic [2:0]      kindSel,
  output logic            bodsEnableWrite,
  output logic            bodsValueWrite,
  output logic            bodsWrData
);
  // idle core: no instruction, arm clear
  initial begin
    sleepInstr      = 1'b0;
    armBit          = 1'b0;
    kindSel         = 3'h0;
    bodsEnableWrite = 1'b0;
    bodsValueWrite  = 1'b0;
    bodsWrData      = 1'b0;
  end

  // arm and kind written with the one-cycle sleep pulse
  task automatic sleep_op(input logic arm, input logic [2:0] kind);
    @(posedge sys_clk);
    #1;
    armBit     = arm;
    kindSel    = kind;
    sleepInstr = 1'b1;
    @(posedge sys_clk);
    #1;
    sleepInstr = 1'b0;
  endtask : sleep_op

  // enable pulse then value next cycle, well inside the window
  task automatic brownout_sleep_off_bit_write(input logic timed, input logic val);
    @(posedge sys_clk);
    #1;
    bodsEnableWrite = timed;
    @(posedge sys_clk);
    #1;
    bodsEnableWrite = 1'b0;
    bodsValueWrite  = 1'b1;
    bodsWrData      = val;
    @(posedge sys_clk);
    #1;
    bodsValueWrite  = 1'b0;
    bodsWrData      = ~val; // stale data flipped, not held
  endtask : brownout_sleep_off_bit_write
endmodule : core_model

// ---- dv/testbench.sv ----
// self-checking bench for the sleep-mode controller
`timescale 1ns/1ps
module testbench;
  import sleep_ctrl_pkg::*;
  localparam int SU = 8;
  logic        sys_clk, rst_n, adcEnabled, sysResetReq, external_irq_a, irqALevelMode;
  logic        clkEn, external_irq_b, irqBLevelMode;
  logic [7:0]  src;
  logic        sleepInstr, armBit, bodsEn, bodsVal, bodsDat;
  logic [2:0]  kindSel;
  logic        cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, oscEn, brownoutEn;
  logic        adcStartPulse, coreHold, irqDeliver, resetVector, offBit, asleep;
  int          n_fail, total_checks;
  logic [31:0] rng;

  core_model core (.sys_clk, .sleepInstr, .armBit, .kindSel, .bodsEnableWrite(bodsEn),
    .bodsValueWrite(bodsVal), .bodsWrData(bodsDat));
  sleep_mode_controller #(.STARTUP_CYC(SU)) i_dut (.sys_clk, .rst_n, .clkEn,
    .sleep_arm_bit(armBit), .sleep_kind_select(kindSel), .sleepInstr, .adcEnabled,
    .asyncTimerOn(1'b1), .bodsEnableWrite(bodsEn), .bodsValueWrite(bodsVal),
    .bodsWrData(bodsDat), .sysResetReq, .external_irq_a, .external_irq_b,
    .irqALevelMode, .irqBLevelMode, .pin_change_irq(src[2]), .twoWireMatch(src[1]),
    .watchdogIrq(src[0]), .asyncTimerIrq(src[4]), .timerIrq(src[3]),
    .storeEeReadyIrq(src[5]), .adcDoneIrq(src[6]), .otherIoIrq(src[7]), .cpuClkEn,
    .flashClkEn, .ioClkEn, .adcClkEn, .asyncClkEn, .oscEn, .brownoutEn, .adcStartPulse,
    .coreHold, .irqDeliver, .resetVector, .brownout_sleep_off_bit(offBit), .asleep);

  // clock: 100 ns period
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // model: clock enables {cpu,flash,io,adc,async,osc} per kind
  function automatic logic [5:0] gates(input logic [2:0] k);
    case (k)
      KIND_IDLE:  return 6'h0F;
      KIND_ADCNR: return 6'h07;
      KIND_PSAVE: return 6'h02;
      KIND_STBY:  return 6'h01;
      KIND_XSTBY: return 6'h03;
      default:    return 6'h00;
    endcase
  endfunction : gates

  // model: wake set, bits {other,adc,store,async,timer,pin,twi,wdt}
  function automatic logic [7:0] wmask(input logic [2:0] k);
    case (k)
      KIND_IDLE:              return 8'hFF;
      KIND_ADCNR:             return 8'h67;
      KIND_PSAVE, KIND_XSTBY: return 8'h17;
      default:                return 8'h07;
    endcase
  endfunction : wmask

  function automatic int startup(input logic [2:0] k, input logic brownout_detector);
    if (k == KIND_IDLE || k == KIND_ADCNR) return 1;
    if (brownout_detector) return BOD_WAKE_CYC;
    if (k == KIND_STBY || k == KIND_XSTBY) return STBY_WAKE_CYC;
    return SU;
  endfunction : startup

  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask : step

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // one sleep: entry, gating, stray sources, valid wake, timed resume
  task automatic run_sleep(input logic [2:0] k, input logic brownout_detector);
    logic [7:0] m;
    logic [7:0] inv;
    logic       deep;
    int         p;
    int         n;
    m = wmask(k);
    deep = brownout_detector && k != KIND_IDLE && k != KIND_ADCNR;
    adcEnabled = xs() & 32'h1;
    if (brownout_detector) core.brownout_sleep_off_bit_write(1'b1, 1'b1);
    if (brownout_detector) check("off bit", offBit, 1);
    core.sleep_op(1'b1, k);
    p = adcStartPulse;
    step();
    p += adcStartPulse;
    check("asleep", asleep, 1);
    check("gates", {cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, oscEn}, gates(k));
    check("adc start", p, k == KIND_ADCNR && adcEnabled);
    check("brownout", brownoutEn, !deep);
    // a source outside the wake set must leave it asleep
    inv = ~m & ((k == KIND_ADCNR) ? 8'hE7 : 8'hFF);
    if (inv != 8'h00) begin
      do p = int'(xs() % 32'h8); while (!inv[p]);
      src = 8'h01 << p;
      repeat (6) step();
      check("stray wake", asleep, 1);
      src = 8'h00;
    end
    // edge-mode external line never wakes any mode but idle
    if (k != KIND_IDLE) begin
      irqALevelMode = 1'b0;
      external_irq_a = 1'b1;
      repeat (8) step();
      check("edge wake", asleep, 1);
      external_irq_a = 1'b0;
      repeat (6) step();
    end
    do p = int'(xs() % 32'h8); while (!m[p]);
    src = 8'h01 << p;
    for (n = 0; n < 20 && asleep; n++) step();
    check("woke", asleep, 0);
    for (n = 0; n < 1000 && !irqDeliver; n++) step();
    check("resume cycles", n, startup(k, brownout_detector) + IRQ_HOLD_CYC);
    src = 8'h00;
    step();
    check("resumed", {coreHold, brownoutEn, cpuClkEn}, 3'b011);
    if (brownout_detector) core.brownout_sleep_off_bit_write(1'b1, 1'b0);
    $display("test done: kind %0d bod %0d", k, brownout_detector);
  endtask : run_sleep

  // level wake in power-down, line held or dropped at wake
  task automatic level_wake(input logic hold);
    int n;
    int d;
    core.sleep_op(1'b1, KIND_PDOWN);
    if (hold) begin
      irqALevelMode = 1'b1;
      external_irq_a = 1'b1;
    end else begin
      irqBLevelMode = 1'b1;
      external_irq_b = 1'b1;
    end
    for (n = 0; n < 20 && asleep; n++) step();
    check("level woke", asleep, 0);
    if (!hold) external_irq_b = 1'b0;
    d = 0;
    repeat (30) begin
      d += irqDeliver;
      step();
    end
    check("level irq", d, hold);
    external_irq_a = 1'b0;
    external_irq_b = 1'b0;
    irqBLevelMode = 1'b0;
    repeat (6) step();
    $display("test done: level hold %0d", hold);
  endtask : level_wake

  initial begin
    int n;
    int rv;
    n_fail = 0;
    total_checks = 0;
    rng = 32'h13CD619E;
    rst_n = 1'b0;
    adcEnabled = 1'b0;
    sysResetReq = 1'b0;
    external_irq_a = 1'b0;
    irqALevelMode = 1'b0;
    clkEn = 1'b1;
    external_irq_b = 1'b0;
    irqBLevelMode = 1'b0;
    src = 8'h00;
    repeat (12) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    check("reset gates", {cpuClkEn, flashClkEn, ioClkEn, adcClkEn, asyncClkEn, oscEn}, 6'h3F);
    check("reset off bit", offBit, BROWNOUT_SLEEP_OFF_BIT_RESET);
    core.brownout_sleep_off_bit_write(1'b0, 1'b1);
    check("untimed write", offBit, 0);
    core.sleep_op(1'b0, KIND_PDOWN);
    check("unarmed", {asleep, cpuClkEn}, 2'b01);
    for (int k = 0; k < 8; k++) begin
      if (k == 4 || k == 5) begin
        core.sleep_op(1'b1, 3'(k));
        check("reserved", {asleep, cpuClkEn}, 2'b01);
      end else begin
        run_sleep(3'(k), 1'b0);
        run_sleep(3'(k), 1'b1);
      end
    end
    level_wake(1'b1);
    level_wake(1'b0);
    // reset while asleep restarts at the vector, no interrupt
    core.sleep_op(1'b1, KIND_PDOWN);
    clkEn = 1'b0;
    sysResetReq = 1'b1;
    repeat (4) step();
    check("frozen", {asleep, resetVector}, 2'b10);
    clkEn = 1'b1;
    rv = 0;
    n = 0;
    repeat (4) begin
      step();
      rv += resetVector;
      n += irqDeliver;
    end
    sysResetReq = 1'b0;
    check("reset vector", rv, 1);
    check("reset irq", {n[0], asleep}, 2'b00);
    $display("test done: reset in sleep");
    wrap_up();
  end

  // watchdog well beyond the expected run of some 3k cycles
  initial begin
    #5000000;
    n_fail++;
    $display("wrong value run time expected done seen hang");
    wrap_up();
  end
endmodule : testbench
